// ### verilog/pcs_pkg.sv
package pcs_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] PCS_IDX_PCLK_CTRL = 32'h0FFFF82F;
  localparam logic [31:0] PCS_IDX_LOOP_CTRL = 32'hFFFFF820;
  localparam logic [31:0] PCS_IDX_LOCK_STAT = 32'hFFFFF824;
  localparam logic [31:0] PCS_IDX_LOCK_SEL  = 32'hFFFFF828;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PCS_LOOP_EN_BIT  = 0;
  localparam int PCS_CLK_SEL_BIT  = 1;
  localparam int PCS_UNLOCK_BIT   = 0;
  localparam int PCS_PCL_EN_BIT   = 4;
  localparam int PCS_PCL_DIV_LSB  = 0;
  localparam int PCS_LOCK_SEL_LSB = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PCS_RST_LOOP_CTRL = 8'h01;
  localparam logic [7:0] PCS_RST_LOCK_STAT = 8'h00;
  localparam logic [7:0] PCS_RST_LOCK_SEL  = 8'h03;
  localparam logic [7:0] PCS_RST_PCLK_CTRL = 8'h00;
  localparam logic       PCS_RST_UNLOCKED  = 1'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          PCS_MULT_FACTOR   = 4;
  localparam int          PCS_CNT_W         = 20;
  localparam logic [31:0] PCS_LOCK_BASE_LOG = 32'h0000000A;
  localparam int          PCS_STOP_SETTLE   = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCS_TMR_OFF,
    PCS_TMR_OST,
    PCS_TMR_LOCK,
    PCS_TMR_STAB
  } pcs_tmr_t;

  typedef enum logic [2:0] {
    PCS_REG_NONE,
    PCS_REG_LOOP,
    PCS_REG_LOCK,
    PCS_REG_LSEL,
    PCS_REG_PCLK
  } pcs_reg_t;

  typedef struct packed {
    logic       stop_mode;
    logic       deep_idle_mode;
    logic       light_idle_mode;
    logic       main_osc_stop_bit;
    logic       clock_divider_msb;
  } pcs_pwr_t;

  typedef struct packed {
    logic       loop_run;
    logic       clock_source_select;
    logic       sys_clk_operable;
  } pcs_clk_t;

endpackage

// ### verilog/pcs_pcl_div.sv
`timescale 1ns/10ps

// programmable clock output divider, pin low while disabled
module pcs_pcl_div (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  // control
  input  wire logic       en,
  input  wire logic [1:0] div,
  // pin
  output logic            pcl_o
);

  typedef struct packed {
    logic [3:0] cnt;
    logic       lvl;
  } pcs_div_st_t;

  pcs_div_st_t st_reg;
  pcs_div_st_t st_next;
  logic [3:0]  half_m1;

  // ----------------------------------------------------------------
  // divide by 2, 4, 8 or 16: toggle every 2^div cycles
  // ----------------------------------------------------------------
  always_comb begin
    half_m1 = 4'((5'h01 << div) - 5'h01);
    st_next = st_reg;
    if (!en) begin
      st_next.cnt = 4'h0;
      st_next.lvl = 1'b0;                          // R16
    end else if (st_reg.cnt >= half_m1) begin
      st_next.cnt = 4'h0;
      st_next.lvl = ~st_reg.lvl;                   // R17
    end else begin
      st_next.cnt = st_reg.cnt + 4'h1;
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign pcl_o = st_reg.lvl;

endmodule

// ### verilog/pcs_ctrl.sv
`timescale 1ns/10ps

// Overview of operation
// R1 - system clock pin follows internal clock while operable, low while stopped
// R2 - system clock pin is high impedance until port bit selects output
// R3 - multiplied mode gives four times oscillator clock, else clock-through
// R4 - loop control resets with loop running and clock-through selected
// R5 - source select bit: 0 clock-through, 1 multiplied clock
// R6 - clearing loop enable also clears source select by hardware
// R7 - select can be set to 1 only while locked, else stores 0
// R8 - lock status bit reads 0 locked, 1 unlocked, updated by events
// R9 - unlock set on reset, deep idle, stop, loop off, main clock stop
// R10 - unlock cleared when default stabilization count expires after reset
// R11 - after stop with loop running, cleared at programmed stabilization overflow
// R12 - loop enable rising runs lockup timer; overflow clears unlock flag
// R13 - after deep idle with loop running, cleared when setup time elapses
// R14 - lockup select picks 2^10..2^13 cycles, resets to longest
// R15 - software keeps lockup at least 800 us and unchanged during lockup
// R16 - programmable clock enable drives pin, pin low when disabled
// R17 - programmable divider code 0..3 divides by 2, 4, 8, 16
// R18 - software enables programmable output only while loop runs
// R19 - software start and stop sequences with lock wait and eight clocks
// R20 - loop stops in deep idle or stop, prior state restored on release
// R21 - software programs stabilization timer for stop and deep idle
// R22 - lockup counter on oscillator clock restarts at each enable rise
module pcs_ctrl #(
  parameter logic [19:0] OST_DEFAULT_CYC = 20'h08000,
  parameter logic [19:0] LOCK_BASE_CYC   = 20'h00400
) (
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                ce,
  // ahb-lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // power state and stabilization count
  input  wire pcs_pkg::pcs_pwr_t   pwr,
  input  wire logic [19:0]         stab_count,
  // clock generation control
  output pcs_pkg::pcs_clk_t        clk_ctl,
  // system clock output pin
  input  wire logic                shared_port_bit,
  output logic                     sys_clock_out_pin_o,
  output logic                     sys_clock_out_pin_oe,
  // programmable clock output pin
  output logic                     prog_clock_out_pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                         dp_wr;
    pcs_pkg::pcs_reg_t            dp_reg;
    logic                         loop_enable;
    logic                         clock_source_select;
    logic [1:0]                   lockup_sel;
    logic                         prog_clock_out_enable;
    logic [1:0]                   prog_div;
    logic                         unlocked;
    pcs_pkg::pcs_tmr_t            tmr;
    logic [pcs_pkg::PCS_CNT_W-1:0] cnt;
    logic                         lp_prev;
    logic                         loop_saved;
    logic                         clk_lvl;
    logic [31:0]                  rdata;
  } pcs_st_t;

  pcs_st_t           st_reg;
  pcs_st_t           st_next;
  pcs_pkg::pcs_reg_t ap_reg;
  logic              ap_valid;
  logic              low_power;
  logic              sub_only;
  logic              wr_loop;
  logic [7:0]        wbyte;
  logic [19:0]       lock_cyc;
  logic              tmr_done;

  // ----------------------------------------------------------------
  // address phase decode
  // ----------------------------------------------------------------
  always_comb begin
    ap_valid = hsel && hready && htrans[1];
    if (haddr[31:2] == pcs_pkg::PCS_IDX_LOOP_CTRL[29:0]) begin
      ap_reg = pcs_pkg::PCS_REG_LOOP;
    end else if (haddr[31:2] == pcs_pkg::PCS_IDX_LOCK_STAT[29:0]) begin
      ap_reg = pcs_pkg::PCS_REG_LOCK;
    end else if (haddr[31:2] == pcs_pkg::PCS_IDX_LOCK_SEL[29:0]) begin
      ap_reg = pcs_pkg::PCS_REG_LSEL;
    end else if (haddr[31:2] == pcs_pkg::PCS_IDX_PCLK_CTRL[29:0]) begin
      ap_reg = pcs_pkg::PCS_REG_PCLK;
    end else begin
      ap_reg = pcs_pkg::PCS_REG_NONE;
    end
  end

  // ----------------------------------------------------------------
  // helper terms
  // ----------------------------------------------------------------
  assign low_power = pwr.stop_mode | pwr.deep_idle_mode;
  assign sub_only  = pwr.main_osc_stop_bit & pwr.clock_divider_msb;
  assign wbyte     = hwdata[7:0];
  assign wr_loop   = st_reg.dp_wr && (st_reg.dp_reg == pcs_pkg::PCS_REG_LOOP);
  assign lock_cyc  = 20'(LOCK_BASE_CYC << st_reg.lockup_sel);          // R14
  assign tmr_done  = (st_reg.cnt == 20'h00001);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // data phase follows each accepted address phase
    st_next.dp_wr  = ap_valid && hwrite;
    st_next.dp_reg = ap_valid ? ap_reg : pcs_pkg::PCS_REG_NONE;

    // register writes in the data phase
    if (st_reg.dp_wr) begin
      case (st_reg.dp_reg)
        pcs_pkg::PCS_REG_LOOP: begin
          st_next.loop_enable = wbyte[pcs_pkg::PCS_LOOP_EN_BIT];
          // select may only be set while locked
          st_next.clock_source_select =
            wbyte[pcs_pkg::PCS_CLK_SEL_BIT] & ~st_reg.unlocked;       // R7
        end
        pcs_pkg::PCS_REG_LSEL: begin
          st_next.lockup_sel = wbyte[pcs_pkg::PCS_LOCK_SEL_LSB +: 2];  // R14
        end
        pcs_pkg::PCS_REG_PCLK: begin
          st_next.prog_clock_out_enable = wbyte[pcs_pkg::PCS_PCL_EN_BIT];
          st_next.prog_div = wbyte[pcs_pkg::PCS_PCL_DIV_LSB +: 2];     // R17
        end
        default: begin
        end
      endcase
    end

    // loop off forces clock-through
    if (!st_next.loop_enable) begin
      st_next.clock_source_select = 1'b0;                             // R6
    end

    // stabilization and lockup timers
    if (st_reg.tmr != pcs_pkg::PCS_TMR_OFF) begin
      if (tmr_done) begin
        st_next.tmr      = pcs_pkg::PCS_TMR_OFF;
        st_next.cnt      = '0;
        st_next.unlocked = 1'b0;                                      // R10 R11 R12 R13
      end else begin
        st_next.cnt = st_reg.cnt - 20'h00001;
      end
    end

    // low power entry and release
    st_next.lp_prev = low_power;
    if (low_power && !st_reg.lp_prev) begin
      st_next.loop_saved = st_reg.loop_enable;                        // R20
      st_next.unlocked   = 1'b1;                                      // R9
      st_next.tmr        = pcs_pkg::PCS_TMR_OFF;
      st_next.cnt        = '0;
    end else if (!low_power && st_reg.lp_prev && st_reg.loop_saved) begin
      st_next.tmr = pcs_pkg::PCS_TMR_STAB;                            // R11 R13
      st_next.cnt = (stab_count == 20'h00000) ? 20'h00001 : stab_count;
    end

    // loop enable rise restarts lockup timer
    if (st_next.loop_enable && !st_reg.loop_enable) begin
      st_next.tmr = pcs_pkg::PCS_TMR_LOCK;                            // R12 R22
      st_next.cnt = lock_cyc;
    end

    // loop stop and subclock-only operation mark unlocked
    if (!st_next.loop_enable && st_reg.loop_enable) begin
      st_next.unlocked = 1'b1;                                        // R9
      st_next.tmr      = pcs_pkg::PCS_TMR_OFF;
      st_next.cnt      = '0;
    end
    if (sub_only) begin
      st_next.unlocked = 1'b1;                                        // R9
    end
    if (low_power) begin
      st_next.unlocked = 1'b1;                                        // R9
    end

    // internal clock image toggles while operable
    if (clk_ctl.sys_clk_operable) begin
      st_next.clk_lvl = ~st_reg.clk_lvl;
    end else begin
      st_next.clk_lvl = 1'b0;                                         // R1
    end

    // read data built from the post-write state
    st_next.rdata = 32'h00000000;
    if (ap_valid && !hwrite) begin
      case (ap_reg)
        pcs_pkg::PCS_REG_LOOP: begin
          st_next.rdata[pcs_pkg::PCS_LOOP_EN_BIT] = st_next.loop_enable;
          st_next.rdata[pcs_pkg::PCS_CLK_SEL_BIT] = st_next.clock_source_select;
        end
        pcs_pkg::PCS_REG_LOCK: begin
          st_next.rdata[pcs_pkg::PCS_UNLOCK_BIT] = st_next.unlocked;  // R8
        end
        pcs_pkg::PCS_REG_LSEL: begin
          st_next.rdata[pcs_pkg::PCS_LOCK_SEL_LSB +: 2] = st_next.lockup_sel;
        end
        pcs_pkg::PCS_REG_PCLK: begin
          st_next.rdata[pcs_pkg::PCS_PCL_EN_BIT] = st_next.prog_clock_out_enable;
          st_next.rdata[pcs_pkg::PCS_PCL_DIV_LSB +: 2] = st_next.prog_div;
        end
        default: begin
          st_next.rdata = 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register, reset starts the default stabilization count
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg                       <= '0;
      st_reg.loop_enable           <= pcs_pkg::PCS_RST_LOOP_CTRL[pcs_pkg::PCS_LOOP_EN_BIT]; // R4
      st_reg.clock_source_select   <= pcs_pkg::PCS_RST_LOOP_CTRL[pcs_pkg::PCS_CLK_SEL_BIT]; // R4
      st_reg.lockup_sel            <= pcs_pkg::PCS_RST_LOCK_SEL[1:0];                      // R14
      st_reg.prog_clock_out_enable <= pcs_pkg::PCS_RST_PCLK_CTRL[pcs_pkg::PCS_PCL_EN_BIT];
      st_reg.prog_div              <= pcs_pkg::PCS_RST_PCLK_CTRL[1:0];
      st_reg.unlocked              <= pcs_pkg::PCS_RST_UNLOCKED;                           // R9
      st_reg.tmr                   <= pcs_pkg::PCS_TMR_OST;                                // R10
      st_reg.cnt                   <= OST_DEFAULT_CYC;
      st_reg.loop_saved            <= 1'b1;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // clock generation control
  // ----------------------------------------------------------------
  always_comb begin
    clk_ctl.loop_run            = st_reg.loop_enable & ~low_power;              // R20
    clk_ctl.clock_source_select = st_reg.clock_source_select & ~low_power;      // R3 R5
    clk_ctl.sys_clk_operable    = ~low_power & ~pwr.light_idle_mode &
                                  (st_reg.tmr != pcs_pkg::PCS_TMR_OST);
  end

  // ----------------------------------------------------------------
  // system clock output pin
  // ----------------------------------------------------------------
  assign sys_clock_out_pin_o  = st_reg.clk_lvl;                                 // R1
  assign sys_clock_out_pin_oe = shared_port_bit;                                // R2

  // ----------------------------------------------------------------
  // programmable clock output
  // ----------------------------------------------------------------
  pcs_pcl_div u_pcl_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .en      (st_reg.prog_clock_out_enable),                                    // R16
    .div     (st_reg.prog_div),
    .pcl_o   (prog_clock_out_pin)
  );

  // ----------------------------------------------------------------
  // ahb-lite answer: zero wait, always okay
  // ----------------------------------------------------------------
  assign hrdata    = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule

// ### dv/pcs_ctrl_properties.sv
`timescale 1ns/10ps

// watches bus, clock control and pins of the controller
module pcs_ctrl_properties #(
  parameter logic [19:0] OST_DEFAULT_CYC = 20'h08000,
  parameter logic [19:0] LOCK_BASE_CYC   = 20'h00400
) (
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // bus
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // control and pins
  input wire pcs_pkg::pcs_pwr_t pwr,
  input wire pcs_pkg::pcs_clk_t clk_ctl,
  input wire logic              shared_port_bit,
  input wire logic              sys_clock_out_pin_o,
  input wire logic              sys_clock_out_pin_oe,
  input wire logic              prog_clock_out_pin
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // bus phases
  // ----------------------------------------------------------------
  sequence s_wr(logic [31:0] idx);
    hsel && hready && htrans[1] && hwrite && (haddr[31:2] == idx[29:0]) ##1 1'b1;
  endsequence
  sequence s_rd;
    hsel && hready && htrans[1] && !hwrite ##1 1'b1;
  endsequence

  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  AST_READ_UPPER_ZERO: assert property (s_rd |-> hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_OE_FOLLOWS_PORT: assert property (sys_clock_out_pin_oe == shared_port_bit)
    else $error("clock pin enable differs from port bit");
  AST_SYSCLK_LOW: assert property (!clk_ctl.sys_clk_operable [*2] |-> !sys_clock_out_pin_o)
    else $error("clock pin high while clock stopped");
  AST_SYSCLK_TOGGLE: assert property (clk_ctl.sys_clk_operable [*3] |-> $changed(sys_clock_out_pin_o))
    else $error("clock pin not toggling while operable");
  AST_SEL_NEEDS_LOOP: assert property (clk_ctl.clock_source_select |-> clk_ctl.loop_run)
    else $error("multiplied clock selected with loop stopped");
  AST_LOW_POWER_STOPS_LOOP: assert property ((pwr.stop_mode || pwr.deep_idle_mode) |-> !clk_ctl.loop_run)
    else $error("loop running in deep idle or stop");
  AST_LOOP_OFF_CLEARS_SEL: assert property (s_wr(pcs_pkg::PCS_IDX_LOOP_CTRL) ##0 !hwdata[0]
    |-> ##2 !clk_ctl.loop_run && !clk_ctl.clock_source_select)
    else $error("loop off write left loop or select on");
  AST_PCL_OFF_LOW: assert property (s_wr(pcs_pkg::PCS_IDX_PCLK_CTRL) ##0 !hwdata[4]
    |-> ##3 (!prog_clock_out_pin) [*4])
    else $error("programmable clock pin high while disabled");
endmodule

bind pcs_ctrl pcs_ctrl_properties #(.OST_DEFAULT_CYC(OST_DEFAULT_CYC), .LOCK_BASE_CYC(LOCK_BASE_CYC))
  pcs_ctrl_properties_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pwr(pwr), .clk_ctl(clk_ctl), .shared_port_bit(shared_port_bit), .sys_clock_out_pin_o(sys_clock_out_pin_o),
  .sys_clock_out_pin_oe(sys_clock_out_pin_oe), .prog_clock_out_pin(prog_clock_out_pin));

// ### dv/pll_clock_select_and_output_tb.sv
`timescale 1ns/10ps

module pll_clock_select_and_output_tb;
  localparam logic [19:0] OST_CYC  = 20'h00010;
  localparam logic [19:0] LOCK_CYC = 20'h00004;
  localparam logic [31:0] R_LOOP   = pcs_pkg::PCS_IDX_LOOP_CTRL;
  localparam logic [31:0] R_LOCK   = pcs_pkg::PCS_IDX_LOCK_STAT;
  localparam logic [31:0] R_LSEL   = pcs_pkg::PCS_IDX_LOCK_SEL;
  localparam logic [31:0] R_PCLK   = pcs_pkg::PCS_IDX_PCLK_CTRL;
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel = 1'b1;
  logic [31:0]       haddr = 32'h0;
  logic [1:0]        htrans = 2'h0;
  logic              hwrite = 1'b0;
  logic [31:0]       hwdata = 32'h0;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  pcs_pkg::pcs_pwr_t pwr = '0;
  logic [19:0]       stab_count = 20'h00001;
  pcs_pkg::pcs_clk_t clk_ctl;
  logic              shared_port_bit = 1'b0;
  logic              sys_o;
  logic              sys_oe;
  logic              pcl;
  int                seed = 32'hC9DE7B52;
  int                n_mismatch = 0;
  int                tests_run = 0;

  // 100 MHz clock
  always #5 hclk = ~hclk;

  pcs_ctrl #(.OST_DEFAULT_CYC(OST_CYC), .LOCK_BASE_CYC(LOCK_CYC)) pcs_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwr(pwr), .stab_count(stab_count), .clk_ctl(clk_ctl),
    .shared_port_bit(shared_port_bit), .sys_clock_out_pin_o(sys_o), .sys_clock_out_pin_oe(sys_oe),
    .prog_clock_out_pin(pcl));

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // one single word transfer, entered just after a rising edge
  task automatic bus(input logic [31:0] idx, input logic wr, input logic [7:0] d, output logic [31:0] q);
    haddr  <= {idx[29:0], 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, d, q);
  endtask

  task automatic rdc(input string what, input logic [31:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(idx, 1'b0, 8'h00, q);
    chk(what, {24'h0, exp}, q);
  endtask

  // polls lock status, returns elapsed cycles until it reads locked
  task automatic lock_wait(output int n);
    logic [31:0] q;
    n = 0;
    do begin
      bus(R_LOCK, 1'b0, 8'h00, q);
      n += 2;
    end while (q[0] !== 1'b0 && n < 600);
  endtask

  // span check: seen within [e, e+6]
  task automatic span(input string what, input int e, input int n);
    chk(what, 32'h1, {31'h0, n >= e && n <= e + 6});
  endtask

  task automatic reset_test;
    int n;
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    lock_wait(n);
    span("default stabilization", int'(OST_CYC), n);
    rdc("loop control reset", R_LOOP, 8'h01);
    rdc("lockup select reset", R_LSEL, 8'h03);
    rdc("prog clock reset", R_PCLK, 8'h00);
    rdc("lock status locked", R_LOCK, 8'h00);
    $display("test reset done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (50000) @(posedge hclk);
    n_mismatch++;
    $display("watchdog expired");
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    int s;
    int c0;
    logic [7:0] d;
    reset_test();
    // lockup span per code, select refusal and hardware clear
    for (int c = 0; c < 4; c++) begin
      wr(R_LSEL, 8'(c));
      rdc("lockup select", R_LSEL, 8'(c));
      wr(R_LOOP, 8'h00);
      rdc("lock on loop off", R_LOCK, 8'h01);
      wr(R_LOOP, 8'h03);
      lock_wait(n);
      span("lockup span", int'(LOCK_CYC) << c, n);
      rdc("select while unlocked", R_LOOP, 8'h01);
      wr(R_LOOP, 8'h03);
      rdc("select while locked", R_LOOP, 8'h03);
      chk("multiplied select", 32'h1, {31'h0, clk_ctl.clock_source_select});
      wr(R_LOOP, 8'h00);
      rdc("loop off clears select", R_LOOP, 8'h00);
    end
    repeat (4) begin
      d = 8'($random(seed));
      wr(R_LSEL, d);
      rdc("lockup select random", R_LSEL, d & 8'h03);
    end
    wr(R_LSEL, 8'h00);
    wr(R_LOOP, 8'h01);
    lock_wait(n);
    $display("test lockup done");
    // stop and deep idle entry and release
    for (int m = 0; m < 2; m++) begin
      s = ($random(seed) & 31) + 1;
      stab_count <= 20'(s);
      pwr.stop_mode <= (m == 0);
      pwr.deep_idle_mode <= (m == 1);
      repeat (3) @(posedge hclk);
      chk("loop in low power", 32'h0, {31'h0, clk_ctl.loop_run});
      c0 = 0;
      repeat (6) begin
        @(posedge hclk);
        c0 += sys_o;
      end
      chk("clock pin while stopped", 32'h0, c0);
      rdc("lock in low power", R_LOCK, 8'h01);
      pwr <= '0;
      lock_wait(n);
      span("release settle", s, n);
      rdc("loop restored", R_LOOP, 8'h01);
    end
    pwr.light_idle_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("loop in light idle", 32'h1, {31'h0, clk_ctl.loop_run});
    rdc("lock in light idle", R_LOCK, 8'h00);
    pwr.light_idle_mode <= 1'b0;
    pwr.main_osc_stop_bit <= 1'b1;
    pwr.clock_divider_msb <= 1'b1;
    repeat (3) @(posedge hclk);
    pwr <= '0;
    rdc("lock on main clock stop", R_LOCK, 8'h01);
    rdc("lock held by event", R_LOCK, 8'h01);
    wr(R_LOOP, 8'h00);
    wr(R_LOOP, 8'h01);
    lock_wait(n);
    $display("test low power done");
    // system clock pin and its enable
    repeat (8) begin
      shared_port_bit <= 1'($random(seed));
      @(posedge hclk);
      @(posedge hclk);
      chk("clock pin enable", {31'h0, shared_port_bit}, {31'h0, sys_oe});
    end
    c0 = 0;
    d[0] = sys_o;
    repeat (10) begin
      @(posedge hclk);
      c0 += (sys_o !== d[0]);
      d[0] = sys_o;
    end
    chk("clock pin toggles", 32'd10, c0);
    $display("test clock pin done");
    // programmable clock divider codes
    for (int v = 0; v < 4; v++) begin
      wr(R_PCLK, 8'h10 | 8'(v));
      repeat (40) @(posedge hclk);
      for (int k = 0; k < 2; k++) begin
        n = 0;
        d[0] = pcl;
        while (pcl === d[0] && n < 64) begin
          @(posedge hclk);
          n++;
        end
      end
      chk("prog clock half period", 32'h1 << v, n);
    end
    wr(R_PCLK, 8'h00);
    repeat (4) @(posedge hclk);
    c0 = 0;
    repeat (40) begin
      @(posedge hclk);
      c0 += pcl;
    end
    chk("prog pin while off", 32'h0, c0);
    $display("test prog clock done");
    reset_test();
    report_and_stop();
  end
endmodule
